// File: logic/mise_alu.sv
// Purpose: Arithmetic of compare, decimal adjust and decrement.
// Assumes: Operands are stable for the execute cycle.
// Notes: Purely combinational.
`timescale 1ns/10ps
`include "mise_map.svh"

module mise_alu (
    mise_alu_if.alu a
);
    import mise_pkg::*;

    logic [8:0] diff;
    logic [8:0] lo_fix;
    logic [8:0] hi_fix;

    always_comb
    begin
        diff = {1'b0, a.rval} - {1'b0, a.acc};
        lo_fix = {1'b0, a.acc};
        hi_fix = 9'h000;
        a.res = 8'h00;
        a.c_out = a.c_in;
        a.z_out = 1'b0;
        case (a.op)
            `MISE_OP_CMP:
            begin
                // Carry set means no borrow: register is not below the accumulator.
                a.c_out = ~diff[8];
                a.z_out = (diff[7:0] == 8'h00);
                a.res = diff[7:0];
            end
            `MISE_OP_DADJ:
            begin
                if ((a.acc[3:0] > `MISE_BCD_MAX) || a.dc_in)
                begin
                    lo_fix = {1'b0, a.acc} + {1'b0, `MISE_BCD_FIX};
                end
                hi_fix = lo_fix;
                if ((lo_fix[7:4] > `MISE_BCD_MAX) || a.c_in || lo_fix[8])
                begin
                    hi_fix = {1'b0, lo_fix[7:0]} + {1'b0, `MISE_BCD_FIX << 4};
                end
                a.res = hi_fix[7:0];
                a.c_out = a.c_in | lo_fix[8] | hi_fix[8];
            end
            `MISE_OP_DSKZ:
            begin
                a.res = a.rval - 8'h01;
            end
            default:
            begin
                a.res = 8'h00;
            end
        endcase
        a.res_zero = (a.res == 8'h00);
    end

endmodule : mise_alu

// File: logic/mise_alu_if.sv
// Purpose: Carries operands and results between the executor and its arithmetic unit.
// Assumes: One clock; the unit is purely combinational.
// Notes: None.
`timescale 1ns/10ps

interface mise_alu_if;
    mise_pkg::mise_op_t op;
    logic [7:0] acc;
    logic [7:0] rval;
    logic c_in;
    logic dc_in;
    logic [7:0] res;
    logic c_out;
    logic z_out;
    logic res_zero;

    modport core (output op, output acc, output rval, output c_in, output dc_in,
                  input res, input c_out, input z_out, input res_zero);
    modport alu (input op, input acc, input rval, input c_in, input dc_in,
                 output res, output c_out, output z_out, output res_zero);
endinterface : mise_alu_if

// File: logic/mise_map.svh
// Purpose: Register offsets, field positions and reset values of the instruction subset executor.
// Assumes: 32-bit Avalon-MM data, byte addresses, one aligned word per register.
// Notes: Included by the package and the design files.
`ifndef MISE_MAP_SVH
`define MISE_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define MISE_OFS_CTRL 10'h000
`define MISE_OFS_ACC 10'h004
`define MISE_OFS_STATUS 10'h008
`define MISE_OFS_INSTR 10'h00c
`define MISE_OFS_EXEC 10'h010
`define MISE_OFS_WDT 10'h014
`define MISE_RAM_BASE_BIT 9

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MISE_CTRL_PSA 0
`define MISE_ST_C 0
`define MISE_ST_DC 1
`define MISE_ST_Z 2
`define MISE_ST_PD 3
`define MISE_ST_TO 4
`define MISE_INSTR_D 3
`define MISE_INSTR_RA_LO 8
`define MISE_EXEC_BUSY 0
`define MISE_EXEC_SKIP 1
`define MISE_EXEC_CYC_LO 8

// ----------------------------------------------------------------
// Operation codes and reset values
// ----------------------------------------------------------------
`define MISE_OP_NOP 3'h0
`define MISE_OP_CLRWD 3'h1
`define MISE_OP_CMP 3'h2
`define MISE_OP_DADJ 3'h3
`define MISE_OP_DSKZ 3'h4
`define MISE_RST_STATUS 5'h18
`define MISE_RST_ACC 8'h00
`define MISE_BCD_FIX 8'h06
`define MISE_BCD_MAX 4'h9

`endif

// File: logic/mise_pkg.sv
// Purpose: Types shared by the instruction subset executor files.
// Assumes: Constants come from mise_map.svh.
// Notes: None.
`include "mise_map.svh"

package mise_pkg;

    typedef logic [2:0] mise_op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_SKIP = 3'b100
    } mise_state_t;

endpackage : mise_pkg

// File: logic/mise_top.sv
// Purpose: Executes watchdog clear, compare, decimal adjust and decrement-skip on a small core state.
// Assumes: Avalon-MM slave with byte addresses; inputs synchronous to ref_clk.
// Notes: An instruction is issued by writing byte lane 0 of the instruction register; the bus stalls while it runs.
`timescale 1ns/10ps
`include "mise_map.svh"

module mise_top #(
    parameter int RAM_DEPTH = 128,
    parameter int WDT_W = 8,
    parameter int PSC_W = 8
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import mise_pkg::*;

    mise_alu_if alu_bus ();

    mise_state_t state_r, state_nxt;
    logic [7:0] ram_r [RAM_DEPTH];
    logic [7:0] acc_r, acc_nxt;
    logic [4:0] status_r, status_nxt;
    logic psa_r, psa_nxt;
    logic [2:0] op_r, op_nxt;
    logic dsel_r, dsel_nxt;
    logic [6:0] ra_r, ra_nxt;
    logic skip_r, skip_nxt;
    logic [1:0] cyc_r, cyc_nxt;
    logic [WDT_W-1:0] wdt_r, wdt_nxt;
    logic [PSC_W-1:0] psc_r, psc_nxt;
    logic resp_r, resp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic ram_we;
    logic [6:0] ram_wa;
    logic [7:0] ram_wd;
    logic req;
    logic accept;
    logic is_ram;
    logic [7:0] rval;
    logic exec;

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------
    // One wait state per access; the whole bus stalls while an instruction runs.
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~resp_r;
    assign accept = req & resp_r;
    assign avs_readdata = rdata_r;
    assign is_ram = avs_address[`MISE_RAM_BASE_BIT];
    assign exec = (state_r == ST_EXEC);
    assign rval = ram_r[ra_r];

    assign alu_bus.op = op_r;
    assign alu_bus.acc = acc_r;
    assign alu_bus.rval = rval;
    assign alu_bus.c_in = status_r[`MISE_ST_C];
    assign alu_bus.dc_in = status_r[`MISE_ST_DC];

    mise_alu u_alu (
        .a (alu_bus)
    );

    always_comb
    begin
        resp_nxt = req & ~resp_r & (state_r == ST_IDLE);
        rdata_nxt = rdata_r;
        if (req & ~resp_r & avs_read)
        begin
            rdata_nxt = 32'h0000_0000;
            if (is_ram)
            begin
                rdata_nxt = {24'h00_0000, ram_r[avs_address[8:2]]};
            end
            else
            begin
                case (avs_address)
                    `MISE_OFS_CTRL: rdata_nxt[`MISE_CTRL_PSA] = psa_r;
                    `MISE_OFS_ACC: rdata_nxt[7:0] = acc_r;
                    `MISE_OFS_STATUS: rdata_nxt[4:0] = status_r;
                    `MISE_OFS_INSTR: rdata_nxt[14:0] = {ra_r, 4'h0, dsel_r, op_r};
                    `MISE_OFS_EXEC: rdata_nxt[9:0] = {cyc_r, 6'h00, skip_r, state_r != ST_IDLE};
                    `MISE_OFS_WDT: rdata_nxt[15:0] = {8'(psc_r), 8'(wdt_r)};
                    default: rdata_nxt = 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Execution and register writes
    // ----------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        acc_nxt = acc_r;
        status_nxt = status_r;
        psa_nxt = psa_r;
        op_nxt = op_r;
        dsel_nxt = dsel_r;
        ra_nxt = ra_r;
        skip_nxt = skip_r;
        cyc_nxt = cyc_r;
        ram_we = 1'b0;
        ram_wa = ra_r;
        ram_wd = alu_bus.res;
        // The watchdog runs from the prescaler when it owns it, otherwise from every cycle.
        psc_nxt = psc_r + 1'b1;
        wdt_nxt = wdt_r;
        if (!psa_r || (psc_r == {PSC_W{1'b1}}))
        begin
            wdt_nxt = wdt_r + 1'b1;
        end
        case (state_r)
            ST_IDLE:
            begin
                if (accept & avs_write & ~is_ram)
                begin
                    case (avs_address)
                        `MISE_OFS_CTRL: if (avs_byteenable[0]) psa_nxt = avs_writedata[`MISE_CTRL_PSA];
                        `MISE_OFS_ACC: if (avs_byteenable[0]) acc_nxt = avs_writedata[7:0];
                        `MISE_OFS_STATUS: if (avs_byteenable[0]) status_nxt = avs_writedata[4:0];
                        `MISE_OFS_INSTR:
                        begin
                            if (avs_byteenable[1])
                            begin
                                ra_nxt = avs_writedata[14:8];
                            end
                            if (avs_byteenable[0])
                            begin
                                op_nxt = avs_writedata[2:0];
                                dsel_nxt = avs_writedata[`MISE_INSTR_D];
                                state_nxt = ST_EXEC;
                            end
                        end
                        default: state_nxt = ST_IDLE;
                    endcase
                end
                else if (accept & avs_write & avs_byteenable[0])
                begin
                    ram_we = 1'b1;
                    ram_wa = avs_address[8:2];
                    ram_wd = avs_writedata[7:0];
                end
            end
            ST_EXEC:
            begin
                state_nxt = ST_IDLE;
                skip_nxt = 1'b0;
                cyc_nxt = 2'h1;
                case (op_r)
                    `MISE_OP_CLRWD:
                    begin
                        wdt_nxt = '0;
                        if (psa_r)
                        begin
                            psc_nxt = '0;
                        end
                        status_nxt[`MISE_ST_TO] = 1'b1;
                        status_nxt[`MISE_ST_PD] = 1'b1;
                    end
                    `MISE_OP_CMP:
                    begin
                        // Result is dropped; only the flags move.
                        status_nxt[`MISE_ST_C] = alu_bus.c_out;
                        status_nxt[`MISE_ST_Z] = alu_bus.z_out;
                    end
                    `MISE_OP_DADJ:
                    begin
                        acc_nxt = alu_bus.res;
                        status_nxt[`MISE_ST_C] = alu_bus.c_out;
                    end
                    `MISE_OP_DSKZ:
                    begin
                        if (dsel_r)
                        begin
                            ram_we = 1'b1;
                        end
                        else
                        begin
                            acc_nxt = alu_bus.res;
                        end
                        if (alu_bus.res_zero)
                        begin
                            state_nxt = ST_SKIP;
                            skip_nxt = 1'b1;
                            cyc_nxt = 2'h2;
                        end
                    end
                    default: state_nxt = ST_IDLE;
                endcase
            end
            ST_SKIP: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= ST_IDLE;
            acc_r <= `MISE_RST_ACC;
            status_r <= `MISE_RST_STATUS;
            psa_r <= 1'b0;
            op_r <= `MISE_OP_NOP;
            dsel_r <= 1'b0;
            ra_r <= 7'h00;
            skip_r <= 1'b0;
            cyc_r <= 2'h0;
            wdt_r <= '0;
            psc_r <= '0;
            resp_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            state_r <= state_nxt;
            acc_r <= acc_nxt;
            status_r <= status_nxt;
            psa_r <= psa_nxt;
            op_r <= op_nxt;
            dsel_r <= dsel_nxt;
            ra_r <= ra_nxt;
            skip_r <= skip_nxt;
            cyc_r <= cyc_nxt;
            wdt_r <= wdt_nxt;
            psc_r <= psc_nxt;
            resp_r <= resp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // The data registers hold no reset so they map onto plain storage.
    always_ff @(posedge ref_clk)
    begin
        if (ram_we)
        begin
            ram_r[ram_wa] <= ram_wd;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_clr_wdt_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
        exec && op_r == `MISE_OP_CLRWD |=> wdt_r == '0 && (!$past(psa_r) || psc_r == '0))
        else $error("watchdog clear left the counter nonzero");

    a_clr_flag_set: assert property (@(posedge ref_clk) disable iff (!arst_n)
        exec && op_r == `MISE_OP_CLRWD |=> status_r == ($past(status_r) | 5'h18))
        else $error("watchdog clear changed the wrong status bits");

    a_cmp_flag_val: assert property (@(posedge ref_clk) disable iff (!arst_n)
        exec && op_r == `MISE_OP_CMP |=> status_r[`MISE_ST_Z] == ($past(rval) == $past(acc_r))
        && status_r[`MISE_ST_DC] == $past(status_r[`MISE_ST_DC]))
        else $error("compare zero flag wrong");

    a_cmp_carry_dir: assert property (@(posedge ref_clk) disable iff (!arst_n)
        exec && op_r == `MISE_OP_CMP |=> status_r[`MISE_ST_C] == ($past(rval) >= $past(acc_r)))
        else $error("compare carry flag wrong");

    a_cmp_keep_ops: assert property (@(posedge ref_clk) disable iff (!arst_n)
        exec && op_r == `MISE_OP_CMP |=> $stable(acc_r) && rval == $past(rval) && state_r == ST_IDLE)
        else $error("compare disturbed an operand or took extra cycles");

    a_daa_only_carry: assert property (@(posedge ref_clk) disable iff (!arst_n)
        exec && op_r == `MISE_OP_DADJ |=> status_r[4:1] == $past(status_r[4:1]))
        else $error("decimal adjust changed a flag other than carry");

    a_daa_bcd_keep: assert property (@(posedge ref_clk) disable iff (!arst_n)
        exec && op_r == `MISE_OP_DADJ && acc_r[3:0] <= 4'h9 && acc_r[7:4] <= 4'h9
        && !status_r[`MISE_ST_C] && !status_r[`MISE_ST_DC] |=> $stable(acc_r) && !status_r[`MISE_ST_C])
        else $error("decimal adjust altered a valid decimal value");

    a_dec_to_acc: assert property (@(posedge ref_clk) disable iff (!arst_n)
        exec && op_r == `MISE_OP_DSKZ && !dsel_r |=> acc_r == 8'($past(rval) - 8'h01))
        else $error("decrement result not in accumulator");

    a_dec_skip_two: assert property (@(posedge ref_clk) disable iff (!arst_n)
        exec && op_r == `MISE_OP_DSKZ && rval == 8'h01 |=> state_r == ST_SKIP ##1 state_r == ST_IDLE)
        else $error("zero decrement did not take two cycles");

endmodule : mise_top

// File: tb/mise_top_bench.sv
// Purpose: Self-checking bench for the instruction subset executor, driven over Avalon-MM.
// Assumes: Map and operation codes of mise_map.svh; data file words are written before use.
// Notes: Reads queue their expected value; a monitor compares each one as the read completes.
`timescale 1ns/10ps
`include "mise_map.svh"

module mise_top_bench;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [31:0] exp_q[$];
    logic [31:0] mask_q[$];
    logic [31:0] rng = 32'h0000_0049;
    logic [7:0] acc;
    logic [7:0] r;
    logic [6:0] ra;
    logic [4:0] st;
    logic d;
    logic [8:0] t;
    int bad_count = 0;
    int num_checks = 0;

    mise_top mise_top_inst (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest)
    );

    always #10 ref_clk = ~ref_clk;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction : xs

    // Packed decimal correction of an 8-bit sum; bit 8 is the carry.
    function logic [8:0] dadj(input logic [7:0] a, input logic c, input logic dc);
        logic [8:0] v;
        v = {c, a};
        if (a[3:0] > 4'h9 || dc)
            v[7:0] = v[7:0] + 8'h06;
        if (v[7:4] > 4'h9 || c)
        begin
            v[8] = 1'b1;
            v[7:0] = v[7:0] + 8'h60;
        end
        return v;
    endfunction : dadj

    function logic [9:0] ra_addr(input logic [6:0] a);
        return {1'b1, a, 2'b00};
    endfunction : ra_addr

    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: read 0x%08h, expected 0x%08h", $time, seen, exp);
        end
    endtask : check

    task end_of_test;
        $display("Checks: %0d, mismatches: %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    // ----------------------------------------------------------------
    // Bus master
    // ----------------------------------------------------------------
    task wait_ack;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge ref_clk);
    endtask : wait_ack

    task bus_wr(input logic [9:0] a, input logic [31:0] v, input logic [3:0] be);
        avs_address <= a;
        avs_writedata <= v;
        avs_byteenable <= be;
        avs_write <= 1'b1;
        wait_ack();
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask : bus_wr

    task bus_rd(input logic [9:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e & m);
        mask_q.push_back(m);
        avs_address <= a;
        avs_read <= 1'b1;
        wait_ack();
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask : bus_rd

    task issue(input logic [2:0] op, input logic dd, input logic [6:0] a);
        bus_wr(`MISE_OFS_INSTR, {17'h00000, a, 4'h0, dd, op}, 4'hf);
    endtask : issue

    task prep;
        bus_wr(ra_addr(ra), {24'h000000, r}, 4'hf);
        bus_wr(`MISE_OFS_ACC, {24'h000000, acc}, 4'hf);
        bus_wr(`MISE_OFS_STATUS, {27'h0000000, st}, 4'hf);
    endtask : prep

    // ----------------------------------------------------------------
    // Monitor
    // ----------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
        begin
            if (exp_q.size() == 0)
                check(avs_readdata, 32'hxxxx_xxxx);
            else
                check(avs_readdata & mask_q.pop_front(), exp_q.pop_front());
        end
    end

    // The whole run needs a few thousand cycles; this limit leaves a wide margin.
    initial
    begin
        #1000000;
        bad_count++;
        end_of_test();
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        bus_rd(`MISE_OFS_CTRL, 32'h0000_0000, 32'hffff_ffff);
        bus_rd(`MISE_OFS_ACC, 32'h0000_0000, 32'hffff_ffff);
        bus_rd(`MISE_OFS_STATUS, 32'h0000_0018, 32'hffff_ffff);
        bus_rd(`MISE_OFS_EXEC, 32'h0000_0000, 32'hffff_ffff);
        bus_wr(10'h01c, 32'h0000_00a5, 4'hf);
        bus_rd(10'h01c, 32'h0000_0000, 32'hffff_ffff);
        bus_wr(`MISE_OFS_ACC, 32'h0000_005a, 4'he);
        bus_rd(`MISE_OFS_ACC, 32'h0000_0000, 32'hffff_ffff);
        // Watchdog clear with the prescaler elsewhere, then assigned to the watchdog.
        bus_wr(`MISE_OFS_STATUS, 32'h0000_0007, 4'hf);
        repeat (300) @(posedge ref_clk);
        issue(`MISE_OP_CLRWD, 1'b0, 7'h00);
        bus_rd(`MISE_OFS_STATUS, 32'h0000_001f, 32'hffff_ffff);
        bus_rd(`MISE_OFS_WDT, 32'h0000_0000, 32'h0000_00f0);
        bus_wr(`MISE_OFS_CTRL, 32'h0000_0001, 4'hf);
        repeat (600) @(posedge ref_clk);
        issue(`MISE_OP_CLRWD, 1'b0, 7'h00);
        bus_rd(`MISE_OFS_WDT, 32'h0000_0000, 32'h0000_f0ff);
        bus_rd(`MISE_OFS_EXEC, 32'h0000_0100, 32'hffff_ffff);
        // Lane 1 alone moves the register address and issues nothing.
        bus_wr(`MISE_OFS_INSTR, 32'h0000_2a00, 4'h2);
        bus_rd(`MISE_OFS_INSTR, 32'h0000_2a01, 32'hffff_ffff);
        for (int i = 0; i < 24; i++)
        begin
            rng = xs(rng);
            acc = rng[7:0];
            r = rng[15:8];
            ra = rng[22:16];
            st = rng[28:24];
            if (i == 0)
                r = acc;
            if (i == 1)
                r = acc - 8'h01;
            prep();
            issue(`MISE_OP_CMP, 1'b0, ra);
            bus_rd(`MISE_OFS_STATUS, {27'h0, st[4:3], r == acc, st[1], r >= acc}, 32'hffff_ffff);
            bus_rd(`MISE_OFS_ACC, {24'h0, acc}, 32'hffff_ffff);
            bus_rd(ra_addr(ra), {24'h0, r}, 32'hffff_ffff);
            bus_rd(`MISE_OFS_EXEC, 32'h0000_0100, 32'hffff_ffff);
            bus_rd(`MISE_OFS_INSTR, {17'h0, ra, 4'h0, 1'b0, `MISE_OP_CMP}, 32'hffff_ffff);
        end
        for (int i = 0; i < 16; i++)
        begin
            rng = xs(rng);
            acc = rng[7:0];
            st = rng[12:8];
            if (acc[7:4] == 4'hf)
                acc[7:4] = 4'he;
            if (i == 0)
                acc = 8'h4d;
            if (i == 1)
                acc = 8'h53;
            if (i < 2)
                st = 5'h00;
            t = dadj(acc, st[0], st[1]);
            bus_wr(`MISE_OFS_ACC, {24'h0, acc}, 4'hf);
            bus_wr(`MISE_OFS_STATUS, {27'h0, st}, 4'hf);
            issue(`MISE_OP_DADJ, 1'b0, 7'h00);
            bus_rd(`MISE_OFS_ACC, {24'h0, t[7:0]}, 32'hffff_ffff);
            bus_rd(`MISE_OFS_STATUS, {27'h0, st[4:1], t[8]}, 32'hffff_ffff);
        end
        for (int i = 0; i < 24; i++)
        begin
            rng = xs(rng);
            acc = rng[7:0];
            r = rng[15:8];
            ra = rng[22:16];
            st = rng[28:24];
            d = rng[29];
            if (i < 4)
                r = {7'h00, i[1] ^ 1'b1};
            if (i < 4)
                d = i[0];
            prep();
            issue(`MISE_OP_DSKZ, d, ra);
            bus_rd(`MISE_OFS_ACC, {24'h0, d ? acc : r - 8'h01}, 32'hffff_ffff);
            bus_rd(ra_addr(ra), {24'h0, d ? r - 8'h01 : r}, 32'hffff_ffff);
            bus_rd(`MISE_OFS_STATUS, {27'h0, st}, 32'hffff_ffff);
            bus_rd(`MISE_OFS_EXEC, r == 8'h01 ? 32'h0000_0202 : 32'h0000_0100, 32'hffff_ffff);
        end
        end_of_test();
    end
endmodule : mise_top_bench
